// ==== hw/asp_serial_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "asp_params.svh"

module asp_serial_port
    import asp_pkg::*;
(
    // System
    input  wire logic                     clk,
    input  wire logic                     sys_rst,
    // Conversion core side
    input  wire logic                     conv_busy,
    input  wire logic                     result_valid,
    input  wire logic [`ASP_RESULT_W-1:0] result_data,
    // Mode select pins
    input  wire logic                     serial_parallel_select,
    input  wire logic                     output_code_format,
    input  wire logic                     chip_select_n,
    // Shared pins 2..3 (divider select / result bits)
    input  wire logic [`ASP_DIV_W-1:0]    div_pins_in,
    output logic      [`ASP_DIV_W-1:0]    div_pins_out,
    output logic      [`ASP_DIV_W-1:0]    div_pins_oe,
    // Shared pins 4..7 (config inputs / result bits)
    input  wire logic [`ASP_CFG_W-1:0]    cfg_pins_in,
    output logic      [`ASP_CFG_W-1:0]    cfg_pins_out,
    output logic                          cfg_pins_oe,
    // Serial clock pin
    input  wire logic                     serial_clock_in,
    output logic                          serial_clock_out,
    output logic                          serial_clock_oe,
    // Serial outputs
    output logic                          serial_result_out,
    output logic                          frame_marker,
    output logic                          incomplete_read_flag
);

    // Decoded pin roles in serial mode
    logic clock_source_select;
    logic frame_marker_polarity;
    logic serial_clock_invert;
    logic read_mode_or_chain_input;
    logic [`ASP_DIV_W-1:0] serial_clock_divider_select;

    // Three-stage synchronisers for the asynchronous pin inputs
    logic [`ASP_SYNC_W-1:0] sclk_sync, next_sclk_sync;
    logic [`ASP_SYNC_W-1:0] cs_sync, next_cs_sync;
    logic [`ASP_SYNC_W-1:0] chain_sync, next_chain_sync;
    logic sclk_level, next_sclk_level;
    logic cs_level, next_cs_level;
    logic chain_level, next_chain_level;

    // Serial engine state
    asp_state_type                state, next_state;
    logic [`ASP_RESULT_W-1:0]     shreg, next_shreg;
    logic [`ASP_RESULT_W-1:0]     held, next_held;
    logic                         held_new, next_held_new;
    logic [`ASP_CNT_W-1:0]        bit_cnt, next_bit_cnt;
    logic [`ASP_DIV_CNT_W-1:0]    div_cnt, next_div_cnt;
    logic                         mclk, next_mclk;
    logic                         sdo, next_sdo;
    logic                         frame_act, next_frame_act;
    logic                         rderr, next_rderr;
    logic [`ASP_RESULT_W-1:0]     par_word, next_par_word;
    logic                         busy_d, next_busy_d;

    // Format the result: MSB inverted when twos complement chosen
    function automatic logic [`ASP_RESULT_W-1:0] fmt(input logic [`ASP_RESULT_W-1:0] d,
                                                     input logic ob);
        fmt = ob ? d : {~d[`ASP_RESULT_W-1], d[`ASP_RESULT_W-2:0]};
    endfunction : fmt

    // Master half period in system clocks for a divider select
    function automatic logic [`ASP_DIV_CNT_W-1:0] half_period(input logic [`ASP_DIV_W-1:0] s);
        half_period = `ASP_DIV_CNT_W'(`ASP_MCLK_BASE_HALF) << s;
    endfunction : half_period

    // Last bit of the word is standing; a slave turns to chain data here
    function automatic logic word_done(input logic [`ASP_CNT_W-1:0] cnt,
                                       input logic                  slv);
        word_done = slv ? (cnt == `ASP_CNT_W'(`ASP_CHAIN_DELAY))
                        : (cnt == `ASP_CNT_W'(`ASP_RESULT_W));
    endfunction : word_done

    // Pin roles; only valid while serial mode is selected
    // Quasi-static: the host changes them only between reads
    always_comb begin
        clock_source_select         = cfg_pins_in[0];
        frame_marker_polarity       = cfg_pins_in[1];
        serial_clock_invert         = cfg_pins_in[2];
        read_mode_or_chain_input    = cfg_pins_in[3];
        serial_clock_divider_select = div_pins_in;
    end

    // Operating mode decode
    logic master_mode, master_rac, slave_mode;
    always_comb begin
        master_mode = serial_parallel_select && !clock_source_select;
        slave_mode  = serial_parallel_select && clock_source_select;
        master_rac  = master_mode && !read_mode_or_chain_input;
    end

    // Synchroniser next values; a change counts when stages 2 and 3 agree
    always_comb begin
        next_sclk_sync  = {sclk_sync[1:0], serial_clock_in};
        next_cs_sync    = {cs_sync[1:0], chip_select_n};
        // Chain data comes from an upstream part on its own clock
        next_chain_sync = {chain_sync[1:0], read_mode_or_chain_input};
        next_sclk_level  = (sclk_sync[2] == sclk_sync[1]) ? sclk_sync[2] : sclk_level;
        next_cs_level    = (cs_sync[2] == cs_sync[1]) ? cs_sync[2] : cs_level;
        next_chain_level = (chain_sync[2] == chain_sync[1]) ? chain_sync[2] : chain_level;
    end

    // Synchroniser registers; reset levels match the idle pins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sclk_sync   <= '0;
            cs_sync     <= '1;
            chain_sync  <= '0;
            sclk_level  <= 1'b0;
            cs_level    <= 1'b1;
            chain_level <= 1'b0;
        end else begin
            sclk_sync   <= next_sclk_sync;
            cs_sync     <= next_cs_sync;
            chain_sync  <= next_chain_sync;
            sclk_level  <= next_sclk_level;
            cs_level    <= next_cs_level;
            chain_level <= next_chain_level;
        end
    end

    // Slave launch edge: rising, or falling when inverted; gated by select
    logic sclk_prev, next_sclk_prev;
    logic slave_launch;
    logic master_tick, master_launch;
    always_comb begin
        next_sclk_prev = sclk_level;
        slave_launch = slave_mode && !cs_level &&
                       (serial_clock_invert ? (sclk_prev && !sclk_level)
                                            : (!sclk_prev && sclk_level));
        // Divider wraps once per half period of the master clock
        master_tick   = (div_cnt == '0);
        // Master shifts on its own falling edge; data stable at the rising edge
        master_launch = master_tick && mclk;
    end

    // Serial engine next values
    logic conv_done;
    always_comb begin
        // Defaults: hold everything but rderr (cleared) and busy_d (sampled), free-run the master divider
        next_state     = state;
        next_shreg     = shreg;
        next_held      = held;
        next_held_new  = held_new;
        next_bit_cnt   = bit_cnt;
        next_div_cnt   = master_tick ? (master_rac ? half_period(serial_clock_divider_select)
                                                   : half_period('0)) - 1'b1
                                     : div_cnt - 1'b1;
        next_mclk      = master_tick ? !mclk : mclk;
        next_sdo       = sdo;
        next_frame_act = frame_act;
        next_rderr     = 1'b0;
        next_busy_d    = conv_busy;
        // Busy falling edge marks a finished conversion
        conv_done      = busy_d && !conv_busy;
        next_par_word  = par_word;

        // Latch each new result
        if (result_valid) begin
            next_held     = fmt(result_data, output_code_format);
            next_held_new = 1'b1;
            next_par_word = next_held;
        end

        case (state)
            ASP_IDLE: begin
                // Master waits for a new result in the right busy phase
                next_frame_act = 1'b0;
                next_bit_cnt   = '0;
                if (master_mode && held_new && master_launch &&
                    (read_mode_or_chain_input ? conv_busy : !conv_busy)) begin
                    next_shreg     = {held[`ASP_RESULT_W-2:0], 1'b0};
                    next_sdo       = held[`ASP_RESULT_W-1];
                    next_held_new  = result_valid;
                    next_frame_act = 1'b1;
                    next_bit_cnt   = `ASP_CNT_W'(1);
                    next_state     = ASP_SHIFT;
                end else if (slave_launch) begin
                    // Slave needs no new result; it reads what is held
                    next_shreg    = {held[`ASP_RESULT_W-2:0], 1'b0};
                    next_sdo      = held[`ASP_RESULT_W-1];
                    next_held_new = result_valid;
                    next_bit_cnt  = `ASP_CNT_W'(1);
                    next_state    = ASP_SHIFT;
                end
            end
            ASP_SHIFT: begin
                if (slave_mode && cs_level && word_done(bit_cnt, 1'b1)) begin
                    // Whole word out and select released: read is complete
                    next_state = ASP_IDLE;
                end else if (slave_mode && conv_done) begin
                    next_rderr = 1'b1;
                    next_state = ASP_IDLE;
                end else if ((master_mode && master_launch) ||
                             (slave_mode && slave_launch)) begin
                    // Next bit on each launch edge of the active mode
                    if (word_done(bit_cnt, slave_mode)) begin
                        if (slave_mode) begin
                            next_sdo   = chain_level;
                            next_state = ASP_CHAIN;
                        end else begin
                            next_frame_act = 1'b0;
                            next_state     = ASP_IDLE;
                        end
                    end else begin
                        next_sdo     = shreg[`ASP_RESULT_W-1];
                        next_shreg   = {shreg[`ASP_RESULT_W-2:0], 1'b0};
                        next_bit_cnt = bit_cnt + 1'b1;
                    end
                end
                // Mode pins left serial: abandon the read
                if (!master_mode && !slave_mode)
                    next_state = ASP_IDLE;
            end
            ASP_CHAIN: begin
                // Pass upstream bits through until the host drops select
                if (slave_launch)
                    next_sdo = chain_level;
                if (!slave_mode || cs_level)
                    next_state = ASP_IDLE;
            end
            default: next_state = ASP_IDLE;
        endcase
    end

    // Serial engine registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state     <= ASP_IDLE;
            shreg     <= '0;
            held      <= '0;
            held_new  <= 1'b0;
            bit_cnt   <= '0;
            div_cnt   <= '0;
            mclk      <= 1'b0;
            sdo       <= 1'b0;
            frame_act <= 1'b0;
            rderr     <= 1'b0;
            busy_d    <= 1'b0;
            sclk_prev <= 1'b0;
            par_word  <= '0;
        end else begin
            state     <= next_state;
            shreg     <= next_shreg;
            held      <= next_held;
            held_new  <= next_held_new;
            bit_cnt   <= next_bit_cnt;
            div_cnt   <= next_div_cnt;
            mclk      <= next_mclk;
            sdo       <= next_sdo;
            frame_act <= next_frame_act;
            rderr     <= next_rderr;
            busy_d    <= next_busy_d;
            sclk_prev <= next_sclk_prev;
            par_word  <= next_par_word;
        end
    end

    // Pin drive; output enables follow the mode pins directly
    always_comb begin
        // Parallel role of the shared pins
        div_pins_out  = par_word[`ASP_DIV_HI_BIT:`ASP_DIV_LO_BIT];
        div_pins_oe   = serial_parallel_select ? '0 : '1;
        cfg_pins_out  = par_word[`ASP_CFG_HI_BIT:`ASP_CFG_LO_BIT];
        cfg_pins_oe   = !serial_parallel_select;
        // Serial role: clock pin and outputs
        serial_clock_out = mclk ^ serial_clock_invert;
        serial_clock_oe  = master_mode;
        serial_result_out    = sdo;
        frame_marker         = frame_act ^ frame_marker_polarity;
        incomplete_read_flag = rderr;
    end

endmodule : asp_serial_port
`default_nettype wire

// ==== hw/asp_params.svh ====
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH

// Result width and daisy-chain delay in serial clock periods
`define ASP_RESULT_W      16
`define ASP_CHAIN_DELAY   16
// Bit counter width (holds 0..16)
`define ASP_CNT_W         5
// Shared pin group positions within the parallel result word
`define ASP_DIV_LO_BIT    2
`define ASP_DIV_HI_BIT    3
`define ASP_CFG_LO_BIT    4
`define ASP_CFG_HI_BIT    7
`define ASP_DIV_W         2
`define ASP_CFG_W         4
// Master clock: half period = BASE << divider select, in system clocks
`define ASP_MCLK_BASE_HALF 2
`define ASP_DIV_CNT_W     8
// Input synchroniser depth
`define ASP_SYNC_W        3

`endif

// ==== hw/asp_pkg.sv ====
package asp_pkg;
    // Serial port engine states
    typedef enum logic [1:0] {
        ASP_IDLE,
        ASP_SHIFT,
        ASP_CHAIN
    } asp_state_type;
endpackage : asp_pkg

// ==== sim/asp_chk_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "asp_params.svh"
module asp_chk (
    // Clock and reset
    input wire logic                  clk,
    input wire logic                  sys_rst,
    // Watched pins
    input wire logic                  conv_busy,
    input wire logic                  serial_parallel_select,
    input wire logic [`ASP_DIV_W-1:0] div_pins_in,
    input wire logic [`ASP_DIV_W-1:0] div_pins_oe,
    input wire logic [`ASP_CFG_W-1:0] cfg_pins_in,
    input wire logic                  cfg_pins_oe,
    input wire logic                  serial_clock_out,
    input wire logic                  serial_clock_oe,
    input wire logic                  frame_marker,
    input wire logic                  incomplete_read_flag
);
    logic        mst;
    logic        act;
    logic [11:0] cnt;
    logic [11:0] next_cnt;
    // Frame length counter; short blips from polarity changes are ignored below
    assign mst = serial_parallel_select & ~cfg_pins_in[0];
    assign act = frame_marker ^ cfg_pins_in[1];
    always_comb next_cnt = act ? cnt + 12'h001 : 12'h000;
    always_ff @(posedge clk) cnt <= sys_rst ? 12'h000 : next_cnt;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    par_pins_a: assert property (!serial_parallel_select ##1 !serial_parallel_select
        |-> div_pins_oe == 2'h3 && cfg_pins_oe) else $error("parallel pins not driven");
    div_hiz_a: assert property (serial_parallel_select ##1 serial_parallel_select
        |-> div_pins_oe == 2'h0) else $error("divider pins driven in serial mode");
    mclk_drive_a: assert property (mst ##1 mst |-> serial_clock_oe)
        else $error("master clock not driven");
    slave_hiz_a: assert property (!mst && serial_parallel_select ##1 !mst
        |-> !serial_clock_oe && !cfg_pins_oe) else $error("slave clock pin driven");
    rst_sync_a: assert property (disable iff (1'b0) sys_rst ##1 sys_rst &&
        $stable(cfg_pins_in) |-> frame_marker == cfg_pins_in[1]) else $error("idle frame level");
    rst_sclk_a: assert property (disable iff (1'b0) sys_rst ##1 sys_rst &&
        $stable(cfg_pins_in) |-> serial_clock_out == cfg_pins_in[2]) else $error("idle clock level");
    flag_pulse_a: assert property (incomplete_read_flag |-> cfg_pins_in[0]
        ##1 !incomplete_read_flag) else $error("read error flag not a slave pulse");
    frame_len_a: assert property ($fell(act) && mst && cnt > 12'h002
        |-> cnt == (12'h040 << (cfg_pins_in[3] ? 2'h0 : div_pins_in)))
        else $error("master frame length");
    start_after_a: assert property ($rose(act) && mst && !cfg_pins_in[3]
        && $stable(cfg_pins_in) |-> !$past(conv_busy)) else $error("read during busy");
    start_during_a: assert property ($rose(act) && mst && cfg_pins_in[3]
        && $stable(cfg_pins_in) |-> $past(conv_busy)) else $error("read outside busy");
endmodule : asp_chk
bind asp_serial_port asp_chk chk (.clk(clk), .sys_rst(sys_rst), .conv_busy(conv_busy),
    .serial_parallel_select(serial_parallel_select), .div_pins_in(div_pins_in),
    .div_pins_oe(div_pins_oe), .cfg_pins_in(cfg_pins_in), .cfg_pins_oe(cfg_pins_oe),
    .serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe),
    .frame_marker(frame_marker), .incomplete_read_flag(incomplete_read_flag));
`default_nettype wire

// ==== sim/asp_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module asp_host_model (
    // System and device pins
    input  wire logic clk,
    input  wire logic sdo,
    input  wire logic sclk_dev,
    input  wire logic master,
    input  wire logic inv,
    // Host driven pins and received bits
    output logic        sclk_host,
    output logic        cs_n,
    output logic [31:0] rx
);
    logic mclk_q = 1'b0;
    initial sclk_host = 1'b0;
    initial cs_n = 1'b1;
    initial rx = 32'h0;
    // Master capture on the rising internal clock, mid-bit
    always @(posedge clk) begin
        mclk_q <= sclk_dev ^ inv;
        if (master && !mclk_q && (sclk_dev ^ inv))
            rx <= {rx[30:0], sdo};
    end
    // Clock only inside the frame, slow for the input synchroniser
    task automatic slave_read(input int nbits);
        cs_n <= 1'b0;
        sclk_host <= inv;
        repeat (12) @(posedge clk);
        for (int i = 0; i < nbits; i++) begin
            sclk_host <= ~inv;
            repeat (12) @(posedge clk);
            sclk_host <= inv;
            rx <= {rx[30:0], sdo};
            repeat (12) @(posedge clk);
        end
        cs_n <= 1'b1;
    endtask : slave_read
endmodule : asp_host_model
`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk = 1'b0, sys_rst = 1'b1, busy = 1'b0, rv = 1'b0, fmt = 1'b1, sps = 1'b0;
    logic [15:0] rd = 16'h0000, w = 16'h0000;
    logic [3:0]  cfg = 4'h0, cpo;
    logic [1:0]  div = 2'h0, dpo, dpe;
    logic        cpe, sco, scoe, sdo, frm, flag, hclk, cs_n, seen;
    logic [31:0] rx;
    int          cycles = 0, num_errors = 0, n_tests = 0;
    always #4 clk = ~clk;
    asp_serial_port dut (.clk(clk), .sys_rst(sys_rst), .conv_busy(busy), .result_valid(rv),
        .result_data(rd), .serial_parallel_select(sps), .output_code_format(fmt),
        .chip_select_n(cs_n), .div_pins_in(div), .div_pins_out(dpo), .div_pins_oe(dpe),
        .cfg_pins_in(cfg), .cfg_pins_out(cpo), .cfg_pins_oe(cpe), .serial_clock_in(hclk),
        .serial_clock_out(sco), .serial_clock_oe(scoe), .serial_result_out(sdo),
        .frame_marker(frm), .incomplete_read_flag(flag));
    asp_host_model host (.clk(clk), .sdo(sdo), .sclk_dev(sco), .master(scoe), .inv(cfg[2]),
        .sclk_host(hclk), .cs_n(cs_n), .rx(rx));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask : check
    // One result from the core, then a few settling cycles
    task automatic give(input logic [15:0] v);
        @(posedge clk);
        rv <= 1'b1;
        rd <= v;
        @(posedge clk);
        rv <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : give
    task automatic wait_frame(input logic lvl);
        int i;
        for (i = 0; i < 400 && frm !== lvl; i++) @(posedge clk);
        check("frame marker", 32'h1, {31'h0, i < 400});
    endtask : wait_frame
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // Hang guard, far above the some 1300 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        w = 16'hA5C3;
        give(w);
        check("parallel pins", {23'h0, w[7:2], 3'h7}, {23'h0, cpo, dpo, cpe, dpe});
        $display("parallel test done");
        // Config changes only between transfers
        sps <= 1'b1;
        cfg <= 4'hA;
        fmt <= 1'b0;
        w = 16'h3C5A;
        give(w);
        busy <= 1'b1;
        wait_frame(1'b0);
        wait_frame(1'b1);
        busy <= 1'b0;
        check("read during word", {16'h0, w ^ 16'h8000}, {16'h0, rx[15:0]});
        $display("master read during test done");
        cfg <= 4'h4;
        div <= 2'h1;
        fmt <= 1'b1;
        w = 16'h81E7;
        give(w);
        wait_frame(1'b1);
        wait_frame(1'b0);
        check("read after word", {16'h0, w}, {16'h0, rx[15:0]});
        $display("master read after test done");
        cfg <= 4'hD;
        fmt <= 1'b0;
        w = 16'h4D29;
        give(w);
        host.slave_read(20);
        check("slave chain word", {12'h0, w ^ 16'h8000, 4'hF}, {12'h0, rx[19:0]});
        $display("slave chain test done");
        // Slave with plain clock sense: data launched on rising edges
        cfg <= 4'h1;
        w = 16'h5AC6;
        give(w);
        host.slave_read(16);
        check("slave plain word", {16'h0, w ^ 16'h8000}, {16'h0, rx[15:0]});
        $display("slave rising edge test done");
        give(16'h1234);
        busy <= 1'b1;
        seen = 1'b0;
        fork
            host.slave_read(8);
            begin
                repeat (100) @(posedge clk);
                busy <= 1'b0;
                repeat (10) @(posedge clk) seen = seen | (flag === 1'b1);
            end
        join
        check("read error flag", 32'h1, {31'h0, seen});
        $display("incomplete read test done");
        stop_test();
    end
endmodule : testbench
`default_nettype wire
